// *** design/mdca_sync_align.sv ***
// module: divided clock generation, multi-device alignment and commit logic
//
// What this block does
// - master emits one-cycle pulse every four cycles
// - slave enable makes device follow received pulses
// - slave compares phase, stalls one cycle on mismatch
// - slaves align within three divided periods
// - two-bit offset compensates zero to three cycles
// - status sets on lost alignment, clears on read
// - status stays high until read or masked
// - mask bit forces status low while set
// - commit clearing software bit stalls divider once
// - each stall shifts divided clock one quarter period
// - hardware mode stalls on each pulse rising edge
// - divide system clock by four, drive out
// - staged data acts only after commit
// - commit strobe sampled on divided clock rising edge
// - setup-met commit gives fixed latency
`timescale 1ns/100ps
`default_nettype none

module mdca_sync_align
	import mdca_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              sync_in,
	input  wire logic              commit_strobe,
	output logic                   sync_clk_out,
	output logic                   sync_pulse_out,
	output logic                   irq
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic mdca_phase_t phase_add(input mdca_phase_t p, input logic [1:0] n);
		phase_add = mdca_phase_t'(2'(p + n));
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	mdca_func_one_t  stage_one_q;
	mdca_func_two_t  stage_two_q;
	mdca_func_one_t  act_one_q;
	mdca_func_two_t  act_two_q;
	mdca_phase_t     phase_q;
	mdca_phase_t     phase_d;
	mdca_phase_t     expect_phase;
	logic            sync_in_q;
	logic            sync_in_prev_q;
	logic            upd_smp_q;
	logic            status_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_events;
	logic [31:0]     prdata_q;
	logic            slverr_q;
	logic            clk_div_q;
	logic            pulse_q;
	logic            setup_ph;
	logic            wr_acc;
	logic            rd_acc;
	logic            mapped;
	logic            sample_edge;
	logic            commit;
	logic            mismatch;
	logic            hw_edge;
	logic            sw_stall;
	logic            stall;
	logic            status_clr;

	// ------------------------------------------------------------------
	// apb slave: zero wait states, read data captured at setup
	// ------------------------------------------------------------------
	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign mapped   = hit(paddr, OFF_FUNC_ONE) | hit(paddr, OFF_FUNC_TWO)
			| hit(paddr, OFF_IRQ_STAT) | hit(paddr, OFF_IRQ_MASK)
			| hit(paddr, OFF_ACTIVE);
	assign pready   = 1'b1;
	assign prdata   = prdata_q;
	assign pslverr  = slverr_q & psel & penable;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (setup_ph) begin
			slverr_q <= ~mapped;
			prdata_q <= 32'h0000_0000;
			if (!pwrite) begin
				case (1'b1)
					hit(paddr, OFF_FUNC_ONE): prdata_q[1:0] <= stage_one_q;
					hit(paddr, OFF_FUNC_TWO): begin
						prdata_q[F2_SLAVE]  <= stage_two_q.slave_en;
						prdata_q[F2_MASTER] <= stage_two_q.master_en;
						prdata_q[F2_STATUS] <= status_q;
						prdata_q[F2_MASK]   <= stage_two_q.mask;
						prdata_q[F2_OFFSET+:2] <= stage_two_q.offset;
					end
					hit(paddr, OFF_IRQ_STAT): prdata_q[IRQ_W-1:0] <= irq_stat_q;
					hit(paddr, OFF_IRQ_MASK): prdata_q[IRQ_W-1:0] <= irq_mask_q;
					hit(paddr, OFF_ACTIVE): begin
						prdata_q[1:0] <= act_one_q;
						prdata_q[ACT_F2_BASE+:5] <= act_two_q;
					end
					default: prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// staging registers, written by software
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage_one_q <= FUNC_ONE_RST;
			stage_two_q <= FUNC_TWO_RST;
		end else begin
			if (wr_acc && hit(paddr, OFF_FUNC_TWO)) begin
				stage_two_q.slave_en  <= pwdata[F2_SLAVE];
				stage_two_q.master_en <= pwdata[F2_MASTER];
				stage_two_q.mask      <= pwdata[F2_MASK];
				stage_two_q.offset    <= pwdata[F2_OFFSET+:2];
			end
			// the commit that consumes the software request also drops it
			if (sw_stall) begin
				stage_one_q.man_sw <= 1'b0;
			end else if (wr_acc && hit(paddr, OFF_FUNC_ONE)) begin
				stage_one_q.man_sw <= pwdata[F1_MAN_SW];
			end
			if (wr_acc && hit(paddr, OFF_FUNC_ONE)) begin
				stage_one_q.man_hw <= pwdata[F1_MAN_HW];
			end
		end
	end

	// ------------------------------------------------------------------
	// commit strobe: sampled on divided clock rising edges only
	// ------------------------------------------------------------------
	// a strobe shorter than one divided period can fall between samples
	assign sample_edge = (phase_q == mdca_phase_t'(SAMPLE_PHASE)) & ~mismatch & ~hw_edge;
	assign commit      = sample_edge & commit_strobe & ~upd_smp_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			upd_smp_q <= 1'b0;
		end else if (sample_edge) begin
			upd_smp_q <= commit_strobe;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			act_one_q <= FUNC_ONE_RST;
			act_two_q <= FUNC_TWO_RST;
		end else if (commit) begin
			act_one_q.man_hw <= stage_one_q.man_hw;
			act_one_q.man_sw <= act_one_q.man_sw ? 1'b0 : stage_one_q.man_sw;
			act_two_q        <= stage_two_q;
		end
	end

	// ------------------------------------------------------------------
	// stall sources
	// ------------------------------------------------------------------
	// the received pulse marks master phase 0, seen one cycle plus offset late
	assign expect_phase = phase_add(mdca_phase_t'(RX_LATENCY), act_two_q.offset);
	assign mismatch = act_two_q.slave_en & ~act_one_q.man_hw & sync_in_q
			& (phase_q != expect_phase);
	assign hw_edge  = act_one_q.man_hw & sync_in_q & ~sync_in_prev_q;
	assign sw_stall = commit & act_one_q.man_sw;
	assign stall    = mismatch | hw_edge | sw_stall;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync_in_q      <= 1'b0;
			sync_in_prev_q <= 1'b0;
		end else begin
			sync_in_q      <= sync_in;
			sync_in_prev_q <= sync_in_q;
		end
	end

	// ------------------------------------------------------------------
	// divide-by-four state machine and outputs
	// ------------------------------------------------------------------
	always_comb begin
		case (phase_q)
			MDCA_PH0: phase_d = MDCA_PH1;
			MDCA_PH1: phase_d = MDCA_PH2;
			MDCA_PH2: phase_d = MDCA_PH3;
			MDCA_PH3: phase_d = MDCA_PH0;
			default:  phase_d = MDCA_PH0;
		endcase
		// one held cycle retards the divided clock by 90 degrees
		if (stall) begin
			phase_d = phase_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_q   <= MDCA_PH0;
			clk_div_q <= 1'b0;
			pulse_q   <= 1'b0;
		end else begin
			phase_q   <= phase_d;
			clk_div_q <= phase_d[1];
			pulse_q   <= act_two_q.master_en & (phase_d == MDCA_PH0)
					& (phase_q != MDCA_PH0);
		end
	end

	assign sync_clk_out   = clk_div_q;
	assign sync_pulse_out = pulse_q;

	// ------------------------------------------------------------------
	// alignment status, cleared by a read that returned it high
	// ------------------------------------------------------------------
	assign status_clr = rd_acc & hit(paddr, OFF_FUNC_TWO) & prdata_q[F2_STATUS];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status_q <= 1'b0;
		end else if (act_two_q.mask) begin
			status_q <= 1'b0;
		end else begin
			// set wins over the read clear
			status_q <= (status_q & ~status_clr) | mismatch;
		end
	end

	// ------------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------------
	assign irq_events = {stall, commit, mismatch};

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_stat_q <= IRQ_RST;
		end else if (wr_acc && hit(paddr, OFF_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_events;
		end else begin
			irq_stat_q <= irq_stat_q | irq_events;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq_mask_q <= IRQ_RST;
		end else if (wr_acc && hit(paddr, OFF_IRQ_MASK)) begin
			irq_mask_q <= pwdata[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_pulse_width;
		sync_pulse_out |-> phase_q == MDCA_PH0 ##1 !sync_pulse_out;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse wrong");

	// a commit may switch the master off in mid period, so it must stay on throughout
	property p_pulse_period;
		sync_pulse_out && act_two_q.master_en && !stall
			##1 (!stall && act_two_q.master_en) [*3] |=> sync_pulse_out;
	endproperty
	a_pulse_period: assert property (p_pulse_period) else $error("pulse period");

	property p_slave_stall;
		mismatch |=> phase_q == $past(phase_q);
	endproperty
	a_slave_stall: assert property (p_slave_stall) else $error("no slave stall");

	property p_offset;
		act_two_q.slave_en && !act_one_q.man_hw && sync_in_q && !stall
			|-> phase_q == phase_add(MDCA_PH1, act_two_q.offset);
	endproperty
	a_offset: assert property (p_offset) else $error("offset ignored");

	property p_status_hold;
		status_q && !status_clr && !act_two_q.mask |=> status_q;
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status lost");

	property p_status_rdclr;
		status_clr && !mismatch && !act_two_q.mask |=> !status_q;
	endproperty
	a_status_rdclr: assert property (p_status_rdclr) else $error("read no clear");

	property p_mask;
		act_two_q.mask |=> !status_q;
	endproperty
	a_mask: assert property (p_mask) else $error("mask ignored");

	property p_mismatch_sets;
		mismatch && !act_two_q.mask |=> status_q || $past(act_two_q.mask);
	endproperty
	a_mismatch_sets: assert property (p_mismatch_sets) else $error("status not set");

	property p_sw_stall;
		commit && act_one_q.man_sw |=> !act_one_q.man_sw && phase_q == MDCA_PH1;
	endproperty
	a_sw_stall: assert property (p_sw_stall) else $error("sw stall");

	property p_hw_stall;
		act_one_q.man_hw && $rose(sync_in_q) |=> phase_q == $past(phase_q);
	endproperty
	a_hw_stall: assert property (p_hw_stall) else $error("hw stall");

	property p_divide;
		!stall |=> phase_q == phase_add($past(phase_q), 2'h1) && sync_clk_out == phase_q[1];
	endproperty
	a_divide: assert property (p_divide) else $error("divider");

	property p_commit_edge;
		commit |-> phase_q == MDCA_PH1 && $past(clk_div_q) == 1'b0
			##1 (sync_clk_out || $past(stall));
	endproperty
	a_commit_edge: assert property (p_commit_edge) else $error("commit off edge");

	property p_hold_active;
		!commit |=> act_two_q == $past(act_two_q);
	endproperty
	a_hold_active: assert property (p_hold_active) else $error("active changed");

	property p_commit_copy;
		commit |=> act_two_q == $past(stage_two_q);
	endproperty
	a_commit_copy: assert property (p_commit_copy) else $error("commit lost data");

	property p_pulse_idle;
		!act_two_q.master_en |=> !sync_pulse_out;
	endproperty
	a_pulse_idle: assert property (p_pulse_idle) else $error("pulse while idle");

	property p_sw_clear;
		sw_stall |=> !stage_one_q.man_sw && !act_one_q.man_sw;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("sw bit kept");

	// a pulse held high must stall only once, on its rising edge
	property p_hw_level;
		act_one_q.man_hw && sync_in_q && sync_in_prev_q && !sw_stall
			|=> phase_q == phase_add($past(phase_q), 2'h1);
	endproperty
	a_hw_level: assert property (p_hw_level) else $error("hw level stall");

	c_master_pulse: cover property (act_two_q.master_en ##1 sync_pulse_out);
	c_slave_align: cover property (mismatch ##4 (sync_in_q && !mismatch));
	c_sw_commit: cover property (sw_stall);
	c_hw_edge: cover property (hw_edge);

endmodule

`default_nettype wire

// *** design/mdca_pkg.sv ***
// package: constants and types of the multi-device clock alignment block
package mdca_pkg;

	// ------------------------------------------------------------------
	// register map (byte offsets on the apb bus)
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  OFF_FUNC_ONE = 8'h00;
	localparam logic [7:0]  OFF_FUNC_TWO = 8'h04;
	localparam logic [7:0]  OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0]  OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0]  OFF_ACTIVE   = 8'h10;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int unsigned F1_MAN_SW    = 0;
	localparam int unsigned F1_MAN_HW    = 1;
	localparam int unsigned F2_OFFSET    = 0;
	localparam int unsigned F2_MASK      = 4;
	localparam int unsigned F2_STATUS    = 5;
	localparam int unsigned F2_MASTER    = 6;
	localparam int unsigned F2_SLAVE     = 7;
	localparam int unsigned ACT_F2_BASE  = 8;
	localparam int unsigned IRQ_LOST     = 0;
	localparam int unsigned IRQ_COMMIT   = 1;
	localparam int unsigned IRQ_STALL    = 2;
	localparam int unsigned IRQ_W        = 3;

	// ------------------------------------------------------------------
	// reset values and divider constants
	// ------------------------------------------------------------------
	localparam logic [1:0]  FUNC_ONE_RST = 2'h0;
	localparam logic [4:0]  FUNC_TWO_RST = 5'h00;
	localparam logic [2:0]  IRQ_RST      = 3'h0;
	localparam int unsigned DIV_RATIO    = 4;
	localparam logic [1:0]  SAMPLE_PHASE = 2'h1;
	localparam logic [1:0]  RX_LATENCY   = 2'h1;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MDCA_PH0 = 2'b00,
		MDCA_PH1 = 2'b01,
		MDCA_PH2 = 2'b10,
		MDCA_PH3 = 2'b11
	} mdca_phase_t;

	typedef struct packed {
		logic man_hw;
		logic man_sw;
	} mdca_func_one_t;

	typedef struct packed {
		logic       slave_en;
		logic       master_en;
		logic       mask;
		logic [1:0] offset;
	} mdca_func_two_t;

endpackage

// *** sim/mdca_peer_model.sv ***
// peer master model: alignment pulse source with trace delay, slip and kick
`timescale 1ns/100ps
`default_nettype none

module mdca_peer_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       en,
	input  wire logic       slip,
	input  wire logic       kick,
	input  wire logic [1:0] delay,
	output logic            base,
	output logic            sync_out
);
	logic [1:0] cnt_q;
	logic [2:0] pipe_q;
	logic [3:0] taps;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q  <= 2'h0;
			base   <= 1'b0;
			pipe_q <= 3'h0;
		end else begin
			// a slip holds the count, so every later pulse moves one cycle
			if (!slip)
				cnt_q <= cnt_q + 2'h1;
			base   <= en && cnt_q == 2'h3 && !slip;
			pipe_q <= {pipe_q[1:0], base};
		end
	end

	// master keeps driving the line low between pulses
	assign taps     = {pipe_q, base};
	assign sync_out = taps[delay] | kick;
endmodule

`default_nettype wire

// *** sim/mdca_sync_align_tb.sv ***
// testbench of the multi-device clock alignment block
`timescale 1ns/100ps
`default_nettype none

module mdca_sync_align_tb;
	import mdca_pkg::*;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              sync_in;
	logic              commit_strobe = 1'b0;
	logic              sync_clk_out;
	logic              sync_pulse_out;
	logic              irq;
	logic              en = 1'b0;
	logic              slip = 1'b0;
	logic              kick = 1'b0;
	logic [1:0]        delay = 2'h0;
	logic              base;
	logic [31:0]       r;
	logic              e;
	int                fail_count = 0;
	int                num_checks = 0;
	int                t0, t1, p, h, dbl;
	logic [3:0]        sig;

	mdca_sync_align dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync_in(sync_in), .commit_strobe(commit_strobe),
		.sync_clk_out(sync_clk_out), .sync_pulse_out(sync_pulse_out), .irq(irq));
	mdca_peer_model peer (.clk(clk), .resetn(resetn), .en(en), .slip(slip), .kick(kick),
		.delay(delay), .base(base), .sync_out(sync_in));

	always #12.5 clk = ~clk;

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask

	// strobe held well past one divided period
	task automatic commit();
		commit_strobe <= 1'b1;
		repeat (6) @(posedge clk);
		commit_strobe <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task automatic rise(output int t);
		logic last;
		last = 1'b1;
		repeat (20) begin
			@(posedge clk);
			t = $rtoi($time / 25.0);
			if (sync_clk_out === 1'b1 && last === 1'b0)
				break;
			last = sync_clk_out;
		end
	endtask

	task automatic watch16();
		logic lp;
		p   = 0;
		h   = 0;
		dbl = 0;
		lp  = 1'b0;
		repeat (16) begin
			@(posedge clk);
			p   += int'(sync_pulse_out === 1'b1);
			h   += int'(sync_clk_out === 1'b1);
			dbl += int'(sync_pulse_out === 1'b1 && lp);
			lp  = sync_pulse_out;
		end
	endtask

	task automatic slip_wait();
		slip <= 1'b1;
		@(posedge clk);
		slip <= 1'b0;
		repeat (16) @(posedge clk);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 5; a++)
			rd(8'(a * 4), 32'h0);
		rd(8'h14, 32'h0);
		chk(32'(e), 32'h1);
		apb(1'b1, 8'h04, 32'h40);
		watch16();
		chk(32'(p), 32'h0);
		rd(8'h10, 32'h0);
		commit();
		rd(8'h10, 32'h0800);
		rd(8'h08, 32'h2);
		watch16();
		chk({p[15:0], dbl[15:0]}, {16'h4, 16'h0});
		chk(32'(h), 32'h8);
		apb(1'b1, 8'h0c, 32'h1);
		en <= 1'b1;
		for (int d = 0; d < 4; d++) begin
			delay <= 2'(d);
			apb(1'b1, 8'h04, 32'h80 | d);
			commit();
			repeat (12) @(posedge clk);
			do @(posedge clk); while (base !== 1'b1);
			for (int k = 3; k >= 0; k--) begin
				@(posedge clk);
				sig[k] = sync_clk_out;
			end
			chk(32'(sig), 32'h6);
		end
		apb(1'b0, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h7);
		chk(32'(irq), 32'h0);
		slip_wait();
		chk(32'(irq), 32'h1);
		rd(8'h04, 32'ha3);
		rd(8'h04, 32'h83);
		apb(1'b1, 8'h08, 32'h1);
		chk(32'(irq), 32'h0);
		rd(8'h08, 32'h4);
		apb(1'b1, 8'h0c, 32'h0);
		slip_wait();
		chk(32'(irq), 32'h0);
		apb(1'b1, 8'h04, 32'h93);
		commit();
		apb(1'b0, 8'h04, 32'h0);
		slip_wait();
		rd(8'h04, 32'h93);
		en <= 1'b0;
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		rise(t0);
		commit();
		rise(t1);
		// first commit only arms the software bit; the next one consumes it
		chk(32'((t1 - t0) % 4), 32'h0);
		rd(8'h00, 32'h1);
		rise(t0);
		commit();
		rise(t1);
		chk(32'((t1 - t0) % 4), 32'h1);
		rd(8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h2);
		commit();
		rise(t0);
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		repeat (8) @(posedge clk);
		rise(t1);
		chk(32'((t1 - t0) % 4), 32'h1);
		conclude();
	end

	// run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule

`default_nettype wire
